// ==== bench/line_side_model.sv ====
// Purpose: line-side chip stand-in that drives status levels
// Assumes: bench calls set just after a rising edge
// Notes: counts every settings load that crosses the barrier
`timescale 1ns/1ps
module line_side_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings from the bank
  input wire daa_line_pkg::line_setting_type line_setting,
  input wire logic line_load_strobe,
  // Status levels toward the bank
  output logic hook_request_pin,
  output logic ring_or_pickup_flag,
  output logic line_in_use,
  output logic line_polarity,
  output logic loop_current_ok
);
  int loads = 0;
  int bad_combo = 0;

  // Idle line: direct polarity, loop current present
  initial begin
    hook_request_pin = 1'b0;
    ring_or_pickup_flag = 1'b0;
    line_in_use = 1'b0;
    line_polarity = 1'b1;
    loop_current_ok = 1'b1;
  end

  // New levels {hook, ring, in use, polarity, loop}
  task automatic set(input logic [4:0] v);
    {hook_request_pin, ring_or_pickup_flag, line_in_use, line_polarity, loop_current_ok} <= v;
  endtask

  always @(posedge pclk) begin
    if (presetn && line_load_strobe) begin
      loads++;
      if (line_setting.headroom[1] && (line_setting.impedance == daa_line_pkg::IMP_600_CAP ||
          line_setting.impedance == daa_line_pkg::IMP_900_CAP)) begin
        bad_combo++;
      end
    end
  end
endmodule

// ==== bench/test_daa_line_bank.sv ====
// Purpose: self-checking bench of the line control bank
// Assumes: pready answers in the second access cycle
// Notes: status inputs come from the line-side model
`timescale 1ns/1ps
module test_daa_line_bank;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hook_request_pin;
  logic ring_or_pickup_flag;
  logic line_in_use;
  logic line_polarity;
  logic loop_current_ok;
  logic off_hook;
  logic gain_select_bit;
  logic power_down_bit;
  logic line_status_pin;
  daa_line_pkg::line_setting_type line_setting;
  logic line_load_strobe;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int cmp_count = 0;

  // 100 MHz clock
  always #5 pclk = ~pclk;

  daa_line_bank daa_line_bank_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hook_request_pin(hook_request_pin), .ring_or_pickup_flag(ring_or_pickup_flag),
    .line_in_use(line_in_use), .line_polarity(line_polarity),
    .loop_current_ok(loop_current_ok), .off_hook(off_hook),
    .gain_select_bit(gain_select_bit), .power_down_bit(power_down_bit),
    .line_status_pin(line_status_pin), .line_setting(line_setting),
    .line_load_strobe(line_load_strobe)
  );

  line_side_model line_side_model_i (
    .pclk(pclk), .presetn(presetn), .line_setting(line_setting),
    .line_load_strobe(line_load_strobe), .hook_request_pin(hook_request_pin),
    .ring_or_pickup_flag(ring_or_pickup_flag), .line_in_use(line_in_use),
    .line_polarity(line_polarity), .loop_current_ok(loop_current_ok)
  );

  // Verdict and end of run
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Value comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task automatic drive(input logic [4:0] v);
    @(posedge pclk);
    line_side_model_i.set(v);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // Edges from the cause until the load strobe
  task automatic wait_strobe(input int exp, input string name);
    int n;
    n = 0;
    while (line_load_strobe !== 1'b1 && n < 12) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(name, exp, n);
    if (n >= 12) begin
      end_sim();
    end
  endtask

  task automatic t_reset();
    rdc(8'h00, 32'h4, "control reset");
    rdc(8'h04, 32'h0, "high reset");
    rdc(8'h08, 32'h0, "low reset");
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("pins reset", 32'h4, {28'h0, off_hook, line_status_pin, gain_select_bit,
      power_down_bit});
  endtask

  task automatic t_ctrl();
    wr(8'h00, 32'h7);
    settle();
    chk("gain and power", 32'h3, {30'h0, gain_select_bit, power_down_bit});
    chk("hook idle", 32'h0, {31'h0, off_hook});
    wr(8'h00, 32'h4);
    settle();
    chk("gain and power off", 32'h0, {30'h0, gain_select_bit, power_down_bit});
  endtask

  task automatic t_prog();
    logic [1:0] hr;
    logic [2:0] imp;
    logic sd;
    int k;
    for (int i = 0; i < 8; i++) begin
      imp = i[2:0];
      hr = i[1:0];
      sd = i[0] ^ i[2];
      if (hr[1] && imp[0] && !imp[2]) hr = 2'h1;
      wr(8'h04, {28'h0, hr, imp[2:1]});
      wr(8'h08, {28'h0, sd, imp[0], 2'h0});
      wait_strobe(1, "low write strobe");
      chk("setting", {26'h0, hr, imp, sd}, {26'h0, line_setting});
      rdc(8'h04, {28'h0, hr, imp[2:1]}, "high readback");
      rdc(8'h08, {28'h0, sd, imp[0], 2'h0}, "low readback");
    end
    k = line_side_model_i.loads;
    wr(8'h04, 32'h5);
    repeat (6) @(posedge pclk);
    chk("high only loads", k, line_side_model_i.loads);
    chk("high only setting", {26'h0, hr, imp, sd}, {26'h0, line_setting});
  endtask

  task automatic t_hook();
    drive(5'h13);
    wait_strobe(4, "hook strobe");
    chk("pin off hook", 32'h1, {31'h0, off_hook});
    drive(5'h03);
    settle();
    chk("on hook", 32'h0, {31'h0, off_hook});
    wr(8'h00, 32'hc);
    settle();
    chk("command off hook", 32'h1, {31'h0, off_hook});
    wr(8'h00, 32'h4);
    settle();
    chk("command on hook", 32'h0, {31'h0, off_hook});
  endtask

  task automatic t_status();
    drive(5'h0b);
    settle();
    chk("ring shown", 32'h0, {31'h0, line_status_pin});
    drive(5'h03);
    apb(1'b0, 8'h10, 32'h0);
    wr(8'h00, 32'h0);
    settle();
    chk("activity idle", 32'h1, {31'h0, line_status_pin});
    drive(5'h07);
    // Edge, flag, then pin
    @(posedge pclk);
    settle();
    chk("in use activity", 32'h0, {31'h0, line_status_pin});
    rdc(8'h10, 32'h7, "status read");
    settle();
    chk("activity cleared", 32'h1, {31'h0, line_status_pin});
    drive(5'h17);
    repeat (6) @(posedge pclk);
    drive(5'h1f);
    // Edge, flag, then pin
    @(posedge pclk);
    settle();
    chk("pickup activity", 32'h0, {31'h0, line_status_pin});
  endtask

  task automatic t_loop();
    drive(5'h16);
    settle();
    drive(5'h17);
    wait_strobe(3, "loop return strobe");
    drive(5'h07);
    settle();
    chk("model combos", 32'h0, line_side_model_i.bad_combo);
  endtask

  // Status write restores defaults
  task automatic t_defaults();
    wr(8'h04, 32'h6);
    wr(8'h00, 32'h3);
    wr(8'h10, 32'h0);
    rdc(8'h00, 32'h4, "control after status write");
    rdc(8'h04, 32'h0, "high after status write");
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_prog();
    t_hook();
    t_status();
    t_loop();
    t_defaults();
    end_sim();
  end
endmodule

// ==== hdl/daa_line_bank.sv ====
// Purpose: line control and line-side programming registers on APB
// Assumes: line inputs synchronous to pclk; software writes high before low
// Notes: reading line status clears the activity flag; writing it restores control and settings defaults
//
// Behaviour
// - Off hook when command bit or pin
// - Select low: pin shows inverted activity
// - Select high (reset): pin shows inverted ring
// - Gain bit picks caller-ID and transmit gain
// - Two-bit headroom field, high at reset
// - Three-bit impedance field selects termination
// - Sensor bit zero enables current sensor
// - Push settings on going off hook
// - Push settings on low register write
// - Push settings after loop current returns while off hook
// - Activity set by in-use change while on hook, or by pickup while off hook
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "daa_line_params.svh"
module daa_line_bank (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line-side status inputs
  input wire logic hook_request_pin,
  input wire logic ring_or_pickup_flag,
  input wire logic line_in_use,
  input wire logic line_polarity,
  input wire logic loop_current_ok,
  // Device controls
  output logic off_hook,
  output logic gain_select_bit,
  output logic power_down_bit,
  output logic line_status_pin,
  // Line-side programming
  output daa_line_pkg::line_setting_type line_setting,
  output logic line_load_strobe
);
  daa_line_pkg::bank_state_type s_ff;
  daa_line_pkg::bank_state_type nxt_s;

  logic hook_rise;
  logic loop_rise;
  logic liu_rise;
  logic liu_fall;
  logic pickup_rise;
  logic access;
  logic done;
  logic addr_ok;
  logic [2:0] idx;
  logic hit_ctrl;
  logic hit_high;
  logic hit_low;
  logic hit_status;
  logic wr_ctrl;
  logic wr_high;
  logic wr_low;
  logic wr_status;
  logic rd_status;
  logic activity_set;
  logic [3:0] rd_word;

  // Edges of hook state and line inputs
  edge_detect #(.RESET_LEVEL(1'b0)) hook_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(s_ff.off_hook),
    .rise(hook_rise),
    .fall()
  );
  edge_detect #(.RESET_LEVEL(1'b1)) loop_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(loop_current_ok),
    .rise(loop_rise),
    .fall()
  );
  edge_detect #(.RESET_LEVEL(1'b0)) liu_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(line_in_use),
    .rise(liu_rise),
    .fall(liu_fall)
  );
  edge_detect #(.RESET_LEVEL(1'b0)) pickup_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(ring_or_pickup_flag),
    .rise(pickup_rise),
    .fall()
  );

  // Pushes settings across the barrier
  line_side_loader loader (
    .pclk(pclk),
    .presetn(presetn),
    .load_req(s_ff.load_req),
    .setting(s_ff.setting),
    .applied(line_setting),
    .load_strobe(line_load_strobe)
  );

  // APB decode
  always_comb begin
    idx = paddr[4:2];
    addr_ok = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
    hit_ctrl = addr_ok && (idx == `IDX_LINE_CONTROL);
    hit_high = addr_ok && (idx == `IDX_LSP_HIGH);
    hit_low = addr_ok && (idx == `IDX_LSP_LOW);
    hit_status = addr_ok && (idx == `IDX_LINE_STATUS);
    access = psel && penable;
    done = access && s_ff.resp.ready;
    wr_ctrl = done && pwrite && hit_ctrl;
    wr_high = done && pwrite && hit_high;
    wr_low = done && pwrite && hit_low;
    wr_status = done && pwrite && hit_status;
    rd_status = done && !pwrite && hit_status;
  end

  // Read multiplexer
  always_comb begin
    rd_word = 4'h0;
    if (hit_ctrl) begin
      rd_word = s_ff.ctrl;
    end else if (hit_high) begin
      rd_word = {s_ff.setting.headroom, s_ff.setting.impedance[2:1]};
    end else if (hit_low) begin
      rd_word = {s_ff.setting.sensor_disable, s_ff.setting.impedance[0], 1'b0,
                 `REVID_VALUE};
    end else if (hit_status) begin
      rd_word = {ring_or_pickup_flag, line_in_use, s_ff.activity, line_polarity};
    end
  end

  always_comb begin
    activity_set = s_ff.off_hook ? pickup_rise : (liu_rise | liu_fall);
  end

  // Next state
  always_comb begin
    nxt_s = s_ff;
    // One wait state, then answer
    nxt_s.resp.ready = access && !s_ff.resp.ready;
    nxt_s.resp.slverr = access && !s_ff.resp.ready &&
                        !(hit_ctrl || hit_high || hit_low || hit_status);
    if (access && !s_ff.resp.ready) begin
      nxt_s.resp.rdata = (!pwrite) ? {28'h0000000, rd_word} : 32'h00000000;
    end
    if (wr_ctrl) begin
      nxt_s.ctrl = pwdata[3:0];
    end
    if (wr_high) begin
      nxt_s.setting.headroom = daa_line_pkg::headroom_type'(
        pwdata[`HIGH_HEADROOM_MSB:`HIGH_HEADROOM_LSB]);
      nxt_s.setting.impedance = daa_line_pkg::impedance_type'(
        {pwdata[`HIGH_IMP_MSB:`HIGH_IMP_LSB], s_ff.setting.impedance[0]});
    end
    if (wr_low) begin
      nxt_s.setting.sensor_disable = pwdata[`LOW_SENSOR_BIT];
      nxt_s.setting.impedance = daa_line_pkg::impedance_type'(
        {s_ff.setting.impedance[2:1], pwdata[`LOW_IMP_BIT]});
    end
    // Status write restores defaults
    if (wr_status) begin
      nxt_s.ctrl = `CTRL_RESET;
      nxt_s.setting = `SETTING_RESET;
    end
    if (activity_set) begin
      nxt_s.activity = 1'b1;
    end else if (rd_status) begin
      nxt_s.activity = 1'b0;
    end
    nxt_s.off_hook = s_ff.ctrl.hook_cmd | hook_request_pin;
    nxt_s.status_pin = s_ff.ctrl.status_sel ? ~ring_or_pickup_flag : ~s_ff.activity;
    nxt_s.load_req = hook_rise | wr_low | (loop_rise & s_ff.off_hook);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff.ctrl <= `CTRL_RESET;
      s_ff.setting <= `SETTING_RESET;
      s_ff.activity <= 1'b0;
      s_ff.status_pin <= 1'b1;
      s_ff.off_hook <= 1'b0;
      s_ff.load_req <= 1'b0;
      s_ff.resp <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs from flops
  assign prdata = s_ff.resp.rdata;
  assign pready = s_ff.resp.ready;
  assign pslverr = s_ff.resp.slverr;
  assign off_hook = s_ff.off_hook;
  assign gain_select_bit = s_ff.ctrl.gain_sel;
  assign power_down_bit = s_ff.ctrl.power_down;
  assign line_status_pin = s_ff.status_pin;

  chk_hook_or_pin: assert property (@(posedge pclk) disable iff (!presetn)
    off_hook == ($past(s_ff.ctrl.hook_cmd) | $past(hook_request_pin)))
    else $error("hook state is not command OR pin");

  chk_pin_activity: assert property (@(posedge pclk) disable iff (!presetn)
    !s_ff.ctrl.status_sel |=> (line_status_pin == !$past(s_ff.activity)))
    else $error("status pin does not show inverted activity");

  chk_pin_ring: assert property (@(posedge pclk) disable iff (!presetn)
    s_ff.ctrl.status_sel |=> (line_status_pin == !$past(ring_or_pickup_flag)))
    else $error("status pin does not show inverted ring flag");

  chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> (gain_select_bit == $past(pwdata[1]) &&
                 power_down_bit == $past(pwdata[0])))
    else $error("gain or power-down bit not written");

  chk_headroom_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high |=> (s_ff.setting.headroom == $past(pwdata[3:2])))
    else $error("headroom field not written");

  chk_low_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low |=> (s_ff.setting.sensor_disable == $past(pwdata[3]) &&
                s_ff.setting.impedance[0] == $past(pwdata[2])))
    else $error("sensor or impedance bit not written");

  chk_offhook_load: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(off_hook) |-> ##3 line_load_strobe)
    else $error("no transfer after going off hook");

  chk_low_load: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low |-> ##2 (line_load_strobe && line_setting == $past(s_ff.setting)))
    else $error("no transfer after low register write");

  chk_loop_load: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(loop_current_ok) ##1 s_ff.off_hook) |-> ##2 line_load_strobe)
    else $error("no transfer after loop current returned");

  chk_activity_set: assert property (@(posedge pclk) disable iff (!presetn)
    activity_set |=> s_ff.activity)
    else $error("activity flag missed an event");
endmodule

// ==== hdl/daa_line_params.svh ====
// Purpose: offsets, field positions and reset values of the line control bank
// Assumes: APB byte address equals the register index times four
// Notes: index 3 and 5 and up are not served by this bank
`ifndef DAA_LINE_PARAMS_SVH
`define DAA_LINE_PARAMS_SVH

// Register indices (byte address = index * 4)
`define IDX_LINE_CONTROL 3'h0
`define IDX_LSP_HIGH 3'h1
`define IDX_LSP_LOW 3'h2
`define IDX_LINE_STATUS 3'h4

// Control register bit positions
`define CTRL_HOOK_BIT 3
`define CTRL_STATSEL_BIT 2
`define CTRL_GAIN_BIT 1
`define CTRL_PWD_BIT 0

// High programming register fields
`define HIGH_HEADROOM_MSB 3
`define HIGH_HEADROOM_LSB 2
`define HIGH_IMP_MSB 1
`define HIGH_IMP_LSB 0

// Low programming register fields
`define LOW_SENSOR_BIT 3
`define LOW_IMP_BIT 2
`define LOW_REVID_BIT 0

// Reset values
`define CTRL_RESET 4'h4
`define SETTING_RESET 6'h00
`define REVID_VALUE 1'h0

`endif

// ==== hdl/daa_line_pkg.sv ====
// Purpose: types shared by the line control bank
// Assumes: nothing beyond the params header
// Notes: enum order gives the field encodings
package daa_line_pkg;

  // Control register bits, D3 down to D0
  typedef struct packed {
    logic hook_cmd;
    logic status_sel;
    logic gain_sel;
    logic power_down;
  } line_control_type;

  typedef enum logic [1:0] {
    HEADROOM_HIGH, HEADROOM_NORMAL, HEADROOM_LOW, HEADROOM_LOWEST
  } headroom_type;

  typedef enum logic [2:0] {
    IMP_600, IMP_600_CAP, IMP_900, IMP_900_CAP,
    IMP_COMPLEX_A, IMP_COMPLEX_B, IMP_COMPLEX_LIMIT, IMP_RESERVED
  } impedance_type;

  // Settings pushed across the barrier
  typedef struct packed {
    headroom_type headroom;
    impedance_type impedance;
    logic sensor_disable;
  } line_setting_type;

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } apb_resp_type;

  typedef struct packed {
    line_control_type ctrl;
    line_setting_type setting;
    logic activity;
    logic status_pin;
    logic off_hook;
    logic load_req;
    apb_resp_type resp;
  } bank_state_type;

  typedef struct packed {
    logic prev;
    logic rise;
    logic fall;
  } edge_state_type;

  typedef struct packed {
    line_setting_type applied;
    logic load;
  } loader_state_type;

endpackage

// ==== hdl/edge_detect.sv ====
// Purpose: registered rise and fall detection of one level
// Assumes: input is synchronous to pclk
// Notes: pulses appear one cycle after the level changes
`timescale 1ns/1ps
module edge_detect #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level and its edges
  input wire logic level,
  output logic rise,
  output logic fall
);
  daa_line_pkg::edge_state_type s_ff;
  daa_line_pkg::edge_state_type nxt_s;

  // Compare with last sample
  always_comb begin
    nxt_s.prev = level;
    nxt_s.rise = level & ~s_ff.prev;
    nxt_s.fall = ~level & s_ff.prev;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= {RESET_LEVEL, 1'b0, 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rise = s_ff.rise;
  assign fall = s_ff.fall;
endmodule

// ==== hdl/line_side_loader.sv ====
// Purpose: holds the settings last pushed to the line side
// Assumes: load_req is a one-cycle pulse
// Notes: strobe marks the cycle the applied word changes
`timescale 1ns/1ps
`include "daa_line_params.svh"
module line_side_loader (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request and programmed settings
  input wire logic load_req,
  input wire daa_line_pkg::line_setting_type setting,
  // Applied settings toward the line side
  output daa_line_pkg::line_setting_type applied,
  output logic load_strobe
);
  daa_line_pkg::loader_state_type s_ff;
  daa_line_pkg::loader_state_type nxt_s;

  // Capture on request
  always_comb begin
    nxt_s = s_ff;
    nxt_s.load = load_req;
    if (load_req) begin
      nxt_s.applied = setting;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= {`SETTING_RESET, 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign applied = s_ff.applied;
  assign load_strobe = s_ff.load;

  chk_load_copies_setting: assert property (@(posedge pclk) disable iff (!presetn)
    load_req |=> (load_strobe && applied == $past(setting)))
    else $error("applied settings differ from requested ones");

  chk_load_needs_req: assert property (@(posedge pclk) disable iff (!presetn)
    !load_req |=> (!load_strobe && $stable(applied)))
    else $error("line side changed without a request");
endmodule
